// ===== design/fmh_host.sv
// Host controller driving a 512K x 16 flash module over its strobe pins.
`timescale 1ns/1ns
`default_nettype none
module fmh_host
  import fmh_pkg::*;
#(
  parameter int ADDR_W = 19
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [15:0]       req_wdata_i,
  input  wire logic [1:0]        req_byte_en_i,
  input  wire logic              prog_enable_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [15:0]            rsp_rdata_o,
  output logic                   rsp_error_o,
  output logic                   module_present_o,
  output logic                   module_depth_ok_o,
  output logic                   init_done_o,
  input  wire logic              capacity_pin_hi_i,
  input  wire logic              capacity_pin_mid_i,
  input  wire logic              capacity_pin_lo_i,
  input  wire logic              speed_pin_3_i,
  input  wire logic              speed_pin_2_i,
  input  wire logic              speed_pin_1_i,
  input  wire logic              speed_pin_0_i,
  output logic [16:0]            addr_o,
  output logic [3:0]             word_select_n_o,
  output logic                   output_gate_n_o,
  output logic                   upper_write_strobe_n_o,
  output logic                   lower_write_strobe_n_o,
  output logic                   program_supply_high_o,
  input  wire logic [15:0]       data_lines_i,
  output logic [15:0]            data_lines_o,
  output logic                   data_lines_oe_o
);
  // ==========================================================
  // Presence decode
  logic       present_w;
  logic       depth_ok_w;
  logic [7:0] wait_w;

  fmh_presence u_presence
  (
    .capacity_code_i ({capacity_pin_hi_i, capacity_pin_mid_i, capacity_pin_lo_i}),
    .speed_code_i    ({speed_pin_3_i, speed_pin_2_i, speed_pin_1_i, speed_pin_0_i}),
    .present_o       (present_w),
    .depth_ok_o      (depth_ok_w),
    .wait_cycles_o   (wait_w)
  );

  // ==========================================================
  // Helper function
  function automatic logic [3:0] fmh_select(input logic [1:0] bank);
    logic [3:0] sel;
    sel       = 4'hf;
    sel[bank] = 1'b0;
    return sel;
  endfunction

  // ==========================================================
  // Sequencer
  fmh_state_t  state_r, state_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic [7:0]  wait_r, wait_nxt;
  logic        ready_r, ready_nxt;
  logic        rsp_valid_r, rsp_valid_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        err_r, err_nxt;
  logic        present_r, present_nxt;
  logic        depth_r, depth_nxt;
  logic        done_r, done_nxt;
  logic [16:0] addr_r, addr_nxt;
  logic [3:0]  sel_r, sel_nxt;
  logic        gate_r, gate_nxt;
  logic        weh_r, weh_nxt;
  logic        wel_r, wel_nxt;
  logic        vpp_r, vpp_nxt;
  logic [15:0] dout_r, dout_nxt;
  logic        oe_r, oe_nxt;

  always_comb
  begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    wait_nxt      = wait_r;
    ready_nxt     = 1'b0;
    rsp_valid_nxt = 1'b0;
    rdata_nxt     = rdata_r;
    err_nxt       = err_r;
    present_nxt   = present_r;
    depth_nxt     = depth_r;
    done_nxt      = done_r;
    addr_nxt      = addr_r;
    sel_nxt       = sel_r;
    gate_nxt      = gate_r;
    weh_nxt       = weh_r;
    wel_nxt       = wel_r;
    vpp_nxt       = prog_enable_i;
    dout_nxt      = dout_r;
    oe_nxt        = oe_r;
    case (state_r)
      FMH_ST_INIT:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == FMH_PD_SETTLE)
        begin
          // Presence pins sampled once after they settle.
          present_nxt = present_w;
          depth_nxt   = depth_ok_w;
          wait_nxt    = wait_w;
          done_nxt    = 1'b1;
          ready_nxt   = 1'b1;
          state_nxt   = FMH_ST_IDLE;
        end
      end
      FMH_ST_IDLE:
      begin
        ready_nxt = 1'b1;
        if (req_valid_i && ready_r)
        begin
          ready_nxt = 1'b0;
          cnt_nxt   = 8'h00;
          addr_nxt  = req_addr_i[16:0];
          // Exactly one word pair is selected.
          sel_nxt   = fmh_select(req_addr_i[ADDR_W-1:17]);
          if (!present_r || (req_write_i && !vpp_r))
          begin
            // No module, or write without program supply, is refused.
            err_nxt       = 1'b1;
            sel_nxt       = 4'hf;
            rsp_valid_nxt = 1'b1;
            ready_nxt     = 1'b1;
          end
          else if (req_write_i)
          begin
            err_nxt   = 1'b0;
            gate_nxt  = 1'b1;
            state_nxt = FMH_ST_WRITE;
          end
          else
          begin
            err_nxt   = 1'b0;
            gate_nxt  = 1'b0;
            oe_nxt    = 1'b0;
            state_nxt = FMH_ST_READ;
          end
        end
      end
      FMH_ST_READ:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == wait_r)
        begin
          rdata_nxt     = data_lines_i;
          rsp_valid_nxt = 1'b1;
          gate_nxt      = 1'b1;
          sel_nxt       = 4'hf;
          cnt_nxt       = 8'h00;
          state_nxt     = FMH_ST_RECOVER;
        end
      end
      FMH_ST_WRITE:
      begin
        // Supply is held steady until the strobes have risen.
        vpp_nxt = vpp_r;
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'h00)
        begin
          // Data is set up a cycle before the strobe falls.
          dout_nxt = req_wdata_i;
          oe_nxt   = 1'b1;
        end
        else if (cnt_r == 8'h01)
        begin
          weh_nxt = ~req_byte_en_i[1];
          wel_nxt = ~req_byte_en_i[0];
        end
        else if (cnt_r == FMH_WRITE_CYC)
        begin
          // Data stays driven past the rising edge of the strobe.
          // The strobe rise starts or ends a program or erase pulse.
          weh_nxt   = 1'b1;
          wel_nxt   = 1'b1;
          cnt_nxt   = 8'h00;
          state_nxt = FMH_ST_RECOVER;
        end
      end
      FMH_ST_RECOVER:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'h01)
        begin
          oe_nxt  = 1'b0;
          sel_nxt = 4'hf;
          if (oe_r)
          begin
            rsp_valid_nxt = 1'b1;
          end
          // Software spaces its command writes to keep each pulse long enough.
          ready_nxt = 1'b1;
          state_nxt = FMH_ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = FMH_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state_r     <= FMH_ST_INIT;
      cnt_r       <= 8'h00;
      wait_r      <= FMH_WAIT_SLOW;
      ready_r     <= 1'b0;
      rsp_valid_r <= 1'b0;
      rdata_r     <= 16'h0000;
      err_r       <= 1'b0;
      present_r   <= 1'b0;
      depth_r     <= 1'b0;
      done_r      <= 1'b0;
      addr_r      <= 17'h00000;
      sel_r       <= 4'hf;
      gate_r      <= 1'b1;
      weh_r       <= 1'b1;
      wel_r       <= 1'b1;
      vpp_r       <= 1'b0;
      dout_r      <= 16'h0000;
      oe_r        <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      wait_r      <= wait_nxt;
      ready_r     <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rdata_r     <= rdata_nxt;
      err_r       <= err_nxt;
      present_r   <= present_nxt;
      depth_r     <= depth_nxt;
      done_r      <= done_nxt;
      addr_r      <= addr_nxt;
      sel_r       <= sel_nxt;
      gate_r      <= gate_nxt;
      weh_r       <= weh_nxt;
      wel_r       <= wel_nxt;
      vpp_r       <= vpp_nxt;
      dout_r      <= dout_nxt;
      oe_r        <= oe_nxt;
    end
  end

  assign req_ready_o            = ready_r;
  assign rsp_valid_o            = rsp_valid_r;
  assign rsp_rdata_o            = rdata_r;
  assign rsp_error_o            = err_r;
  assign module_present_o       = present_r;
  assign module_depth_ok_o      = depth_r;
  assign init_done_o            = done_r;
  assign addr_o                 = addr_r;
  assign word_select_n_o        = sel_r;
  assign output_gate_n_o        = gate_r;
  assign upper_write_strobe_n_o = weh_r;
  assign lower_write_strobe_n_o = wel_r;
  assign program_supply_high_o  = vpp_r;
  assign data_lines_o           = dout_r;
  assign data_lines_oe_o        = oe_r;
endmodule // fmh_host
`default_nettype wire

// ===== design/fmh_pkg.sv
// Package of constants and types for the flash module host controller.
package fmh_pkg;
  // Capacity code on capacity_pin_hi/mid/lo; open reads one.
  localparam logic [2:0] FMH_CAP_NONE    = 3'h7;
  localparam logic [2:0] FMH_CAP_512K    = 3'h5;
  // Speed code on speed_pin_3..0; open reads one.
  localparam logic [3:0] FMH_SPEED_120NS = 4'h7;
  localparam logic [3:0] FMH_SPEED_ND    = 4'hf;
  // Read access time of the module in ns and its cycle count at 250 MHz.
  localparam int         FMH_CLK_NS      = 4;
  localparam int         FMH_ACCESS_NS   = 120;
  localparam logic [7:0] FMH_ACCESS_CYC  = 8'((FMH_ACCESS_NS + FMH_CLK_NS - 1) / FMH_CLK_NS);
  // Write count at which the strobes rise; they stay low one cycle fewer.
  localparam logic [7:0] FMH_WRITE_CYC   = 8'h10;
  // Cycles the presence pins settle after reset before sampling.
  localparam logic [7:0] FMH_PD_SETTLE   = 8'h08;
  localparam logic [7:0] FMH_WAIT_SLOW   = 8'hff;
  typedef enum logic [2:0] {
    FMH_ST_INIT,
    FMH_ST_IDLE,
    FMH_ST_READ,
    FMH_ST_WRITE,
    FMH_ST_RECOVER
  } fmh_state_t;
endpackage

// ===== design/fmh_presence.sv
// Presence code decoder: capacity and wait-state count from strap pins.
`timescale 1ns/1ns
`default_nettype none
module fmh_presence
  import fmh_pkg::*;
(
  input  wire logic [2:0] capacity_code_i,
  input  wire logic [3:0] speed_code_i,
  output logic            present_o,
  output logic            depth_ok_o,
  output logic [7:0]      wait_cycles_o
);
  always_comb
  begin
    present_o     = (capacity_code_i != FMH_CAP_NONE);
    depth_ok_o    = (capacity_code_i == FMH_CAP_512K);
    if (speed_code_i == FMH_SPEED_120NS)
    begin
      wait_cycles_o = FMH_ACCESS_CYC;
    end
    else
    begin
      wait_cycles_o = FMH_WAIT_SLOW;
    end
  end
endmodule // fmh_presence
`default_nettype wire

// ===== test/fmh_host_props.sv
// Pin-level assertions for the flash module host controller.
`timescale 1ns/1ns
`default_nettype none
module fmh_host_props #(
  parameter int ADDR_W = 19
)
(
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire logic              req_valid_i,
  input wire logic              req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic              req_ready_o,
  input wire logic              rsp_valid_o,
  input wire logic              rsp_error_o,
  input wire logic              module_present_o,
  input wire logic [3:0]        word_select_n_o,
  input wire logic              output_gate_n_o,
  input wire logic              upper_write_strobe_n_o,
  input wire logic              lower_write_strobe_n_o,
  input wire logic              program_supply_high_o,
  input wire logic              data_lines_oe_o
);
  // ==========
  // Helpers and properties.
  logic       wr_n;
  logic       rd_tk;
  logic [3:0] sel_exp;
  assign wr_n  = upper_write_strobe_n_o & lower_write_strobe_n_o;
  assign rd_tk = req_valid_i & req_ready_o & ~req_write_i & module_present_o;
  always_ff @(posedge ref_clk_i) sel_exp <= ~(4'h1 << req_addr_i[ADDR_W-1 -: 2]);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_one_select: assert property ($countones(~word_select_n_o) <= 1)
    else $error("two word selects low");
  a_gate_strobe: assert property (output_gate_n_o || wr_n)
    else $error("gate and strobe low together");
  a_write_cond: assert property (!wr_n |-> program_supply_high_o && data_lines_oe_o
    && word_select_n_o != 4'hf) else $error("bad write strobe");
  a_strobe_hold: assert property ($fell(wr_n) |-> !wr_n [*8])
    else $error("write strobe too short");
  a_drive_gate: assert property (data_lines_oe_o |-> output_gate_n_o)
    else $error("host drives during read");
  a_read_sel: assert property (rd_tk |=> !output_gate_n_o && word_select_n_o == sel_exp)
    else $error("read select wrong");
  a_read_answer: assert property (rd_tk |-> ##[2:300] rsp_valid_o && !rsp_error_o)
    else $error("read answer late");
  a_low_refuse: assert property (req_write_i && req_valid_i && req_ready_o
    && !program_supply_high_o |=> rsp_valid_o && rsp_error_o && wr_n)
    else $error("low supply write not refused");
  c_read: cover property (rd_tk);
  c_write: cover property ($fell(wr_n));
  c_refuse: cover property (rsp_valid_o && rsp_error_o);
endmodule // fmh_host_props
`default_nettype wire

// ===== test/fmh_flash_model.sv
// Behavioural model of the flash module data side.
`timescale 1ns/1ns
`default_nettype none
module fmh_flash_model (
  input  wire logic [16:0] addr_i,
  input  wire logic [3:0]  sel_n_i,
  input  wire logic        gate_n_i,
  input  wire logic        wu_n_i,
  input  wire logic        wl_n_i,
  input  wire logic        supply_i,
  input  wire logic [15:0] data_i,
  output logic      [15:0] data_o
);
  // ==========
  // Array, command arming and bus drive.
  logic [15:0] mem [bit [18:0]];
  logic [18:0] la_u;
  logic [18:0] la_l;
  logic [1:0]  arm = 2'h0;
  logic [15:0] last = 16'h0;
  logic        upd = 1'b0;
  function automatic logic [18:0] loc();
    return {sel_n_i[0] ? (sel_n_i[1] ? (sel_n_i[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0, addr_i};
  endfunction
  function automatic logic [15:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  // A byte is programmed only by the write that follows a setup command.
  task automatic prog(input int h, input logic [18:0] a, input logic [7:0] v);
    logic [15:0] w;
    w = rd(a);
    if (supply_i && sel_n_i != 4'hf)
    begin
      w[8*h +: 8] = w[8*h +: 8] & v;
      if (arm[h])
      begin
        // The pulse ends at the next write, before any stop timer runs out.
        mem[a] = w;
        upd = ~upd;
      end
      arm[h] = v == 8'h40;
    end
  endtask
  always @(negedge supply_i) arm = 2'h0;
  always @(negedge wu_n_i) la_u = loc();
  always @(negedge wl_n_i) la_l = loc();
  always @(posedge wu_n_i) prog(1, la_u, data_i[15:8]);
  always @(posedge wl_n_i) prog(0, la_l, data_i[7:0]);
  always @(addr_i, sel_n_i, gate_n_i, wu_n_i, wl_n_i, upd)
    if (sel_n_i != 4'hf && !gate_n_i && wu_n_i && wl_n_i)
    begin
      last = rd(loc());
      data_o = last;
    end
    else
      data_o = ~last;
endmodule // fmh_flash_model
`default_nettype wire

// ===== test/fmh_host_bench.sv
// Self-checking bench for the flash module host controller.
`timescale 1ns/1ns
`default_nettype none
module fmh_host_bench
  import fmh_pkg::*;
();
  // ==========
  // Stimulus, model and checks.
  logic        clk, rst, vld, wr, pe, rdy, rv, re, pres, dok, idone, gate_n, su_n, sl_n, sup, oe;
  logic [18:0] ad;
  logic [16:0] mad;
  logic [15:0] wd, rd, dout, bus, mdat;
  logic [3:0]  sel_n;
  logic [2:0]  cap;
  logic [3:0]  spd;
  logic [1:0]  be;
  integer      seed;
  int          n_errors, checks, cyc, lat;
  assign bus = oe ? dout : mdat;
  fmh_host u_dut (.ref_clk_i(clk), .reset_i(rst), .req_valid_i(vld), .req_write_i(wr),
    .req_addr_i(ad), .req_wdata_i(wd), .req_byte_en_i(be), .prog_enable_i(pe),
    .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_rdata_o(rd), .rsp_error_o(re),
    .module_present_o(pres), .module_depth_ok_o(dok), .init_done_o(idone),
    .capacity_pin_hi_i(cap[2]), .capacity_pin_mid_i(cap[1]), .capacity_pin_lo_i(cap[0]),
    .speed_pin_3_i(spd[3]), .speed_pin_2_i(spd[2]), .speed_pin_1_i(spd[1]),
    .speed_pin_0_i(spd[0]),
    .addr_o(mad), .word_select_n_o(sel_n), .output_gate_n_o(gate_n),
    .upper_write_strobe_n_o(su_n), .lower_write_strobe_n_o(sl_n),
    .program_supply_high_o(sup), .data_lines_i(bus), .data_lines_o(dout), .data_lines_oe_o(oe));
  fmh_flash_model u_mod (.addr_i(mad), .sel_n_i(sel_n), .gate_n_i(gate_n), .wu_n_i(su_n),
    .wl_n_i(sl_n), .supply_i(sup), .data_i(bus), .data_o(mdat));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] d, input logic [1:0] b);
    return {b[1] ? d[15:8] : 8'hff, b[0] ? d[7:0] : 8'hff};
  endfunction
  task automatic xfer(input logic w, input logic [18:0] a, input logic [15:0] d,
                      input logic [1:0] b);
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    vld <= 1'b1;
    wr  <= w;
    ad  <= a;
    wd  <= d;
    be  <= b;
    @(posedge clk);
    vld <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
    end
    while (rv !== 1'b1);
  endtask
  task automatic do_reset(input logic [2:0] c, input logic [3:0] s);
    @(posedge clk);
    rst <= 1'b1;
    cap <= c;
    spd <= s;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    do @(negedge clk); while (idone !== 1'b1);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      close_out();
    end
  end
  initial
  begin
    logic [18:0] a [4];
    logic [15:0] d [4];
    {rst, vld, wr, pe, ad, wd, be, cap, spd} = {1'b1, 3'h0, 19'h0, 16'h0, 2'h0, 3'h5, 4'h7};
    seed = 32'hb266c288;
    do_reset(3'h5, 4'h7);
    check("presence", {9'h0, pres, dok, gate_n, sel_n}, 16'h7f);
    a[0] = 19'($random(seed));
    xfer(1'b1, a[0], 16'h4040, 2'h3);
    check("low write", {15'h0, re}, 16'h1);
    $display("test presence done");
    @(posedge clk);
    pe <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      a[k] = {2'(k), 17'($random(seed))};
      d[k] = 16'($random(seed));
      xfer(1'b1, a[k], 16'h4040, 2'(k == 0 ? 3 : k));
      xfer(1'b1, a[k], d[k], 2'(k == 0 ? 3 : k));
      check("write", {15'h0, re}, 16'h0);
    end
    $display("test writes done");
    @(posedge clk);
    pe <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(1'b1, a[1], 16'h0, 2'h3);
    check("late write", {15'h0, re}, 16'h1);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b0, a[k], 16'h0, 2'h0);
      check("read", rd, merge(d[k], 2'(k == 0 ? 3 : k)));
      check("read wait", 16'(lat), 16'(FMH_ACCESS_CYC) + 16'h0002);
    end
    $display("test reads done");
    do_reset(3'h7, 4'h7);
    xfer(1'b0, a[0], 16'h0, 2'h0);
    check("absent", {13'h0, pres, dok, re}, 16'h1);
    $display("test absent done");
    do_reset(3'h5, 4'hf);
    check("slow presence", {14'h0, pres, dok}, 16'h3);
    xfer(1'b0, a[3], 16'h0, 2'h0);
    check("slow read", rd, d[3]);
    check("slow wait", 16'(lat), 16'(FMH_WAIT_SLOW) + 16'h0002);
    $display("test slow done");
    close_out();
  end
endmodule // fmh_host_bench
bind fmh_host fmh_host_props #(.ADDR_W(ADDR_W)) u_props (.ref_clk_i, .reset_i, .req_valid_i,
  .req_write_i, .req_addr_i, .req_ready_o, .rsp_valid_o, .rsp_error_o, .module_present_o,
  .word_select_n_o, .output_gate_n_o, .upper_write_strobe_n_o, .lower_write_strobe_n_o,
  .program_supply_high_o, .data_lines_oe_o);
`default_nettype wire
